// ### verilog/sor_top.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module sor_top
   import sor_pkg::*;
#(
   parameter int NCH = SOR_NUM_CH,
   parameter int SW = 24,
   parameter int AW = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NCH-1:0] sample_valid,
   input wire logic [NCH*SW-1:0] sample_data,
   output logic irq
);
   localparam int HI_W = AW - SOR_IDX_LSB - SOR_IDX_W;

   // write channel holding state
   logic aw_held_q;
   logic [AW-1:0] awaddr_q;
   logic w_held_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic wr_fire;
   logic [3:0] wr_idx;
   logic wr_hit;
   logic wr_ok;
   logic [1:0] wr_resp;

   // read channel state
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic ar_fire;
   logic [3:0] rd_idx;
   logic rd_hit;
   logic [31:0] rd_word;
   logic [1:0] rd_resp;

   // software-visible control
   logic [NCH-1:0] enable_q;
   logic [NCH-1:0] full_vec;
   logic [NCH-1:0] event_vec;
   logic [NCH-1:0] irq_status;
   logic [NCH-1:0] irq_mask;
   logic [NCH-1:0] stat_clr;
   logic mask_we;
   logic [15:0] chan_rd [NCH];

   function automatic logic [3:0] reg_index(input logic [AW-1:0] addr);
      reg_index = addr[SOR_IDX_LSB +: SOR_IDX_W];
   endfunction

   function automatic logic addr_in_range(input logic [AW-1:0] addr);
      addr_in_range = (addr[AW-1 -: HI_W] == '0);
   endfunction

   // ---------------- write address and data capture
   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready = !w_held_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && !aw_held_q) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && !w_held_q) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   // the write takes effect once both halves are in and no response is waiting
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
   assign wr_idx = reg_index(awaddr_q);
   assign wr_hit = addr_in_range(awaddr_q) && sor_is_mapped(wr_idx);
   assign wr_ok = wr_hit && sor_is_writable(wr_idx);

   always_comb begin
      if (!wr_hit) begin
         wr_resp = SOR_RESP_DECERR;
      end else if (!wr_ok) begin
         wr_resp = SOR_RESP_SLVERR;
      end else begin
         wr_resp = SOR_RESP_OKAY;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= SOR_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_resp;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ---------------- register writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_q <= NCH'(SOR_ENABLE_RST);
      end else if (wr_fire && wr_ok && wr_idx == SOR_IDX_ENABLE && wstrb_q[0]) begin
         enable_q <= wdata_q[NCH-1:0];
      end
   end

   assign mask_we = wr_fire && wr_ok && wr_idx == SOR_IDX_IRQ_MASK && wstrb_q[0];

   always_comb begin
      if (wr_fire && wr_ok && wr_idx == SOR_IDX_IRQ_STAT && wstrb_q[0]) begin
         stat_clr = wdata_q[NCH-1:0];
      end else begin
         stat_clr = '0;
      end
   end

   // ---------------- read path
   assign s_axi_arready = !rvalid_q;
   assign ar_fire = s_axi_arvalid && !rvalid_q;
   assign rd_idx = reg_index(s_axi_araddr);
   assign rd_hit = addr_in_range(s_axi_araddr) && sor_is_mapped(rd_idx);

   always_comb begin
      rd_word = '0;
      rd_resp = SOR_RESP_OKAY;
      if (!rd_hit) begin
         rd_resp = SOR_RESP_DECERR;
      end else if (sor_is_chan(rd_idx)) begin
         rd_word = {16'h0000, chan_rd[rd_idx[2:0]]};
      end else begin
         case (rd_idx)
            SOR_IDX_ENABLE: begin
               rd_word = {{(32-NCH){1'b0}}, enable_q};
            end
            SOR_IDX_FULL: begin
               rd_word = {{(32-NCH){1'b0}}, full_vec};
            end
            SOR_IDX_IRQ_STAT: begin
               rd_word = {{(32-NCH){1'b0}}, irq_status};
            end
            SOR_IDX_IRQ_MASK: begin
               rd_word = {{(32-NCH){1'b0}}, irq_mask};
            end
            default: begin
               rd_resp = SOR_RESP_DECERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= SOR_RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_resp;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ---------------- channels
   generate
      for (genvar i = 0; i < NCH; i++) begin : g_ch
         sor_chan_if #(.SW(SW)) ch_if ();

         assign ch_if.enable = enable_q[i];
         assign ch_if.in_valid = sample_valid[i];
         assign ch_if.in_data = sample_data[i*SW +: SW];
         // clear is tied to the read handshake of this channel's register
         assign ch_if.rd_clr = ar_fire && rd_hit && sor_is_chan(rd_idx) &&
            (rd_idx[2:0] == 3'(i));
         assign ch_if.wr_same = wr_fire;
         assign full_vec[i] = ch_if.full;
         assign event_vec[i] = ch_if.new_sample;
         assign chan_rd[i] = ch_if.read_data;

         sor_chan #(
            .SW(SW)
         ) u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .ch(ch_if.chan)
         );
      end
   endgenerate

   // ---------------- interrupts
   sor_irq #(
      .NCH(NCH)
   ) u_irq (
      .aclk(aclk),
      .aresetn(aresetn),
      .events(event_vec),
      .clr_mask(stat_clr),
      .mask_we(mask_we),
      .mask_wdata(wdata_q[NCH-1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );
endmodule // sor_top

// ### verilog/sor_pkg.sv
package sor_pkg;
   localparam int SOR_NUM_CH = 6;
   localparam int SOR_OUT_W = 16;
   localparam int SOR_IDX_W = 4;
   localparam int SOR_IDX_LSB = 2;
   localparam logic [15:0] SOR_SAMPLE_RST = 16'hFFFF;
   localparam logic [15:0] SOR_EMPTY_READ = 16'hFFFF;
   localparam logic [3:0] SOR_IDX_CH0 = 4'h0;
   localparam logic [3:0] SOR_IDX_CH5 = 4'h5;
   localparam logic [3:0] SOR_IDX_ENABLE = 4'h6;
   localparam logic [3:0] SOR_IDX_FULL = 4'h7;
   localparam logic [3:0] SOR_IDX_IRQ_STAT = 4'h8;
   localparam logic [3:0] SOR_IDX_IRQ_MASK = 4'h9;
   localparam logic [5:0] SOR_ENABLE_RST = 6'h00;
   localparam logic [5:0] SOR_MASK_RST = 6'h00;
   localparam logic [5:0] SOR_STAT_RST = 6'h00;
   localparam logic [1:0] SOR_RESP_OKAY = 2'h0;
   localparam logic [1:0] SOR_RESP_SLVERR = 2'h2;
   localparam logic [1:0] SOR_RESP_DECERR = 2'h3;

   function automatic logic sor_is_chan(input logic [3:0] idx);
      sor_is_chan = (idx >= SOR_IDX_CH0) && (idx <= SOR_IDX_CH5);
   endfunction

   function automatic logic sor_is_mapped(input logic [3:0] idx);
      sor_is_mapped = (idx <= SOR_IDX_IRQ_MASK);
   endfunction

   function automatic logic sor_is_writable(input logic [3:0] idx);
      sor_is_writable = (idx == SOR_IDX_ENABLE) || (idx == SOR_IDX_IRQ_STAT) ||
         (idx == SOR_IDX_IRQ_MASK);
   endfunction
endpackage

// ### verilog/sor_chan_if.sv
`timescale 1ns/100ps
interface sor_chan_if #(
   parameter int SW = 24
);
   logic enable;
   logic in_valid;
   logic [SW-1:0] in_data;
   logic rd_clr;
   logic wr_same;
   logic full;
   logic new_sample;
   logic [15:0] read_data;

   modport ctrl (
      output enable,
      output in_valid,
      output in_data,
      output rd_clr,
      output wr_same,
      input full,
      input new_sample,
      input read_data
   );

   modport chan (
      input enable,
      input in_valid,
      input in_data,
      input rd_clr,
      input wr_same,
      output full,
      output new_sample,
      output read_data
   );
endinterface

// ### verilog/sor_chan.sv
`timescale 1ns/100ps
module sor_chan
   import sor_pkg::*;
#(
   parameter int SW = 24
) (
   input wire logic aclk,
   input wire logic aresetn,
   sor_chan_if.chan ch
);
   logic [15:0] sample_q;
   logic full_q;
   logic accept;

   // a disabled filter takes no new samples or events; an unread held sample still reads back
   assign accept = ch.enable & ch.in_valid;
   assign ch.new_sample = accept;
   assign ch.full = full_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_q <= SOR_SAMPLE_RST;
      end else if (accept) begin
         sample_q <= ch.in_data[SW-1 -: SOR_OUT_W];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         full_q <= 1'b0;
      end else if (accept) begin
         full_q <= 1'b1;
      end else if (ch.rd_clr && !ch.wr_same) begin
         full_q <= 1'b0;
      end
   end

   always_comb begin
      if (ch.enable || full_q) begin
         ch.read_data = sample_q;
      end else begin
         ch.read_data = SOR_EMPTY_READ;
      end
   end
endmodule // sor_chan

// ### verilog/sor_irq.sv
`timescale 1ns/100ps
module sor_irq
   import sor_pkg::*;
#(
   parameter int NCH = 6
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [NCH-1:0] events,
   input wire logic [NCH-1:0] clr_mask,
   input wire logic mask_we,
   input wire logic [NCH-1:0] mask_wdata,
   output logic [NCH-1:0] status,
   output logic [NCH-1:0] mask,
   output logic irq
);
   logic [NCH-1:0] status_q;
   logic [NCH-1:0] mask_q;

   // a new event wins over a simultaneous write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= NCH'(SOR_STAT_RST);
      end else begin
         status_q <= (status_q & ~clr_mask) | events;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= NCH'(SOR_MASK_RST);
      end else if (mask_we) begin
         mask_q <= mask_wdata;
      end
   end

   assign status = status_q;
   assign mask = mask_q;
   assign irq = |(status_q & mask_q);
endmodule // sor_irq

// ### bench/sor_top_props.sv
`timescale 1ns/100ps
module sor_top_props
   import sor_pkg::*;
#(
   parameter int NCH = 6
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [NCH-1:0] sample_valid,
   input wire logic irq
);
   logic any_smp;
   assign any_smp = |sample_valid;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_r_wait;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   property p_rst_quiet;
      disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq;
   endproperty
   property p_rd_answer;
      s_rd_take |=> s_axi_rvalid;
   endproperty
   property p_rd_hold;
      s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_rd_width;
      s_axi_rvalid && s_axi_rresp == SOR_RESP_OKAY |-> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   property p_rd_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   property p_irq_cause;
      $rose(irq) |-> $past(any_smp) || $rose(s_axi_bvalid);
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
   a_rd_answer: assert property (p_rd_answer) else $error("no read data");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   a_rd_width: assert property (p_rd_width) else $error("upper bits set");
   a_rd_block: assert property (p_rd_block) else $error("read overlap");
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
endmodule // sor_top_props
bind sor_top sor_top_props #(.NCH(NCH)) u_props (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .sample_valid(sample_valid),
   .irq(irq)
);

// ### bench/sor_filt_model.sv
`timescale 1ns/100ps
module sor_filt_model #(
   parameter int NCH = 6,
   parameter int SW = 24
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req,
   input wire logic [2:0] ch,
   input wire logic [SW-1:0] val,
   output logic [NCH-1:0] sample_valid,
   output logic [NCH*SW-1:0] sample_data
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_valid <= '0;
         sample_data <= '0;
      end else begin
         // idle lanes toggle so stale data never looks valid
         sample_data <= ~sample_data;
         sample_valid <= '0;
         if (req) begin
            sample_valid <= NCH'(1) << ch;
            sample_data[ch*SW +: SW] <= val;
         end
      end
   end
endmodule // sor_filt_model

// ### bench/testbench.sv
`timescale 1ns/100ps
module testbench
   import sor_pkg::*;
;
   logic aclk, aresetn, awv, wv, br, arv, rr, awr, wrdy, bv, arr, rv, irq, preq;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdata, d;
   logic [1:0] bresp, rresp, resp;
   logic [5:0] sv;
   logic [143:0] sd;
   logic [2:0] pch;
   logic [23:0] pval;
   int miscompares = 0;
   int n_compared = 0;
   sor_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .sample_valid(sv), .sample_data(sd), .irq(irq));
   sor_filt_model filt_u (.aclk(aclk), .aresetn(aresetn), .req(preq), .ch(pch), .val(pval),
      .sample_valid(sv), .sample_data(sd));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic stuck;
      miscompares++;
      $display("[FAIL] handshake expected done seen stuck");
      conclude;
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] v);
      bit ta, tw, tb, tv;
      int n;
      @(posedge aclk);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(negedge aclk);
         ta = awv & awr;
         tw = wv & wrdy;
         tv = bv;
         tb = bv & br;
         resp = bresp;
         @(posedge aclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tb) break;
         // ready trails valid so a waiting response is exercised
         if (tv) br <= 1'b1;
      end
      if (n == 60) stuck;
      br <= 1'b0;
   endtask
   task automatic rd(logic [11:0] a);
      bit ta, tr, tv;
      int n;
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(negedge aclk);
         ta = arv & arr;
         tv = rv;
         tr = rv & rr;
         d = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ta) arv <= 1'b0;
         if (tr) break;
         // ready trails valid so held read data is exercised
         if (tv) rr <= 1'b1;
      end
      if (n == 60) stuck;
      rr <= 1'b0;
   endtask
   task automatic push(logic [2:0] c, logic [15:0] top);
      @(posedge aclk);
      preq <= 1'b1;
      pch <= c;
      pval <= {top, 8'h5F};
      @(posedge aclk);
      preq <= 1'b0;
      repeat (2) @(posedge aclk);
      #1;
   endtask
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         rd(12'(i * 4));
         chk("sample", d, 32'h0000FFFF);
      end
      rd(12'h018);
      chk("enable", d, 32'h0);
      rd(12'h024);
      chk("mask", d, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_stream;
      wr(12'h018, 32'h3F);
      wr(12'h024, 32'h3F);
      for (int i = 0; i < 6; i++) push(3'(i), {8'hA0 + 8'(i), 8'h30 + 8'(i)});
      chk("irq", 32'(irq), 32'h1);
      rd(12'h01C);
      chk("flags", d, 32'h3F);
      for (int i = 0; i < 6; i++) begin
         rd(12'(i * 4));
         chk("sample", d, {16'h0, 8'hA0 + 8'(i), 8'h30 + 8'(i)});
      end
      rd(12'h01C);
      chk("flags", d, 32'h0);
      wr(12'h020, 32'h3F);
      chk("irq", 32'(irq), 32'h0);
      push(3'h0, 16'h1111);
      rd(12'h020);
      chk("status", d, 32'h1);
      wr(12'h024, 32'h0);
      #1 chk("irq", 32'(irq), 32'h0);
      $display("stream test done");
   endtask
   task automatic t_disabled;
      wr(12'h018, 32'h3F);
      push(3'h1, 16'h7E81);
      wr(12'h018, 32'h0);
      rd(12'h004);
      chk("held", d, 32'h7E81);
      rd(12'h004);
      chk("empty", d, 32'h0000FFFF);
      $display("disabled test done");
   endtask
   task automatic t_coinc;
      wr(12'h018, 32'h3F);
      push(3'h2, 16'hC35A);
      fork
         wr(12'h024, 32'h0);
         begin
            @(posedge aclk);
            rd(12'h008);
         end
      join
      chk("sample", d, 32'hC35A);
      rd(12'h01C);
      chk("flags", d, 32'h5);
      rd(12'h028);
      chk("unmapped", 32'(resp), 32'(SOR_RESP_DECERR));
      wr(12'h000, 32'h1234);
      chk("ro write", 32'(resp), 32'(SOR_RESP_SLVERR));
      $display("coincident test done");
   endtask
   task automatic t_rerst;
      wr(12'h018, 32'h3F);
      push(3'h3, 16'h9D62);
      rd(12'h00C);
      chk("sample", d, 32'h9D62);
      push(3'h3, 16'h4B17);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h01C);
      chk("flags", d, 32'h0);
      wr(12'h018, 32'h08);
      rd(12'h00C);
      chk("sample", d, 32'h0000FFFF);
      chk("irq", 32'(irq), 32'h0);
      $display("mid-run reset test done");
   endtask
   initial begin
      aresetn = 1'b0;
      {awv, wv, br, arv, rr, preq, awa, ara, wd, pch, pval} = '0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_stream;
      t_disabled;
      t_coinc;
      t_rerst;
      conclude;
   end
endmodule // testbench
